/* src/clock_gating_consts.svh */
// Constants of the power-saving clock control: offsets, fields, resets.
// Assumes a 32-bit APB slave port with word-aligned registers.
`ifndef CLOCK_GATING_CONSTS_SVH
`define CLOCK_GATING_CONSTS_SVH

// Register byte offsets
`define OFS_CLOCK_DIVISOR 12'h000
`define OFS_PWM_AUX 12'h004
`define OFS_MD_TIMERS_SERIAL 12'h008
`define OFS_MD_CAPTURE_COMPARE 12'h00c
`define OFS_MD_COMPARATOR_ENCODER 12'h010
`define OFS_MD_REFCLK 12'h014

// Clock divisor fields
`define BIT_RETURN_ON_INTERRUPT 15
`define MSB_DOZE_RATIO 14
`define LSB_DOZE_RATIO 12
`define BIT_CPU_SLOWDOWN_ENABLE 11

// Writable masks; all other bits are unimplemented and read zero
`define MASK_CLOCK_DIVISOR 16'hf800
`define MASK_PWM_AUX 16'hffff
`define MASK_MD_TIMERS_SERIAL 16'hfefb
`define MASK_MD_CAPTURE_COMPARE 16'h0f0f
`define MASK_MD_COMPARATOR_ENCODER 16'h0422
`define MASK_MD_REFCLK 16'h0008

// Reset values
`define RST_CLOCK_DIVISOR 16'h0000
`define RST_PWM_AUX 16'h0000
`define RST_MODULE_DISABLE 16'h0000

// Divider and module counts
`define DOZE_COUNT_WIDTH 7
`define PWM_GENERATORS 8
`define MODULE_COUNT 26

`endif

/* src/clock_gating_pkg.sv */
// Types shared by the power-saving clock control.
// Assumes the constants header is found on the include path.
`include "clock_gating_consts.svh"

package clock_gating_pkg;

    // APB request as driven by the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    // APB answer as driven by this slave
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    // CPU clocking mode as seen by status logic
    typedef enum logic [0:0] {
        MODE_FULL = 1'b0,
        MODE_DOZE = 1'b1
    } cpu_mode_type;

endpackage : clock_gating_pkg

/* src/power_saving_clock_gating.sv */
// Power-saving clock control: doze divider for the CPU clock enable,
// per-generator fine-resolution disables for the PWM and peripheral
// module disables that gate clocks and register access.
// Assumes one system clock, an APB master and an interrupt request line.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "clock_gating_consts.svh"

module power_saving_clock_gating #(
    // Set bit means the peripheral exists in this variant
    parameter logic [`MODULE_COUNT-1:0] PRESENT_MASK = {`MODULE_COUNT{1'b1}}
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire clock_gating_pkg::apb_req_type apb_req,
    output clock_gating_pkg::apb_rsp_type apb_rsp,
    input wire logic irq_event,
    input wire logic [`MODULE_COUNT-1:0] periph_sel,
    input wire logic periph_wr,
    input wire logic periph_rd,
    output logic cpu_clk_en_q,
    output logic [`MODULE_COUNT-1:0] periph_clk_en_q,
    output logic periph_wr_en_q,
    output logic periph_rd_valid_q,
    output logic [`PWM_GENERATORS-1:0] fine_duty_disable_q,
    output logic [`PWM_GENERATORS-1:0] fine_period_disable_q,
    output logic cpu_mode_q
);
    import clock_gating_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus decode

    logic [15:0] clock_divisor_register_q;
    logic [15:0] pwm_aux_control_q;
    logic [15:0] module_disable_timers_serial_q;
    logic [15:0] module_disable_capture_compare_q;
    logic [15:0] module_disable_comparator_encoder_q;
    logic [15:0] module_disable_refclk_q;
    logic [`DOZE_COUNT_WIDTH-1:0] doze_count_q;
    logic [`MODULE_COUNT-1:0] module_enable_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // Setup phase samples the read data; access phase completes
    wire setup_phase = apb_req.psel & ~apb_req.penable;
    wire access_done = apb_req.psel & apb_req.penable & pready_q;
    wire write_done = access_done & apb_req.pwrite;

    wire sel_div = apb_req.paddr == `OFS_CLOCK_DIVISOR;
    wire sel_aux = apb_req.paddr == `OFS_PWM_AUX;
    wire sel_md1 = apb_req.paddr == `OFS_MD_TIMERS_SERIAL;
    wire sel_md2 = apb_req.paddr == `OFS_MD_CAPTURE_COMPARE;
    wire sel_md3 = apb_req.paddr == `OFS_MD_COMPARATOR_ENCODER;
    wire sel_md4 = apb_req.paddr == `OFS_MD_REFCLK;
    wire sel_any = sel_div | sel_aux | sel_md1 | sel_md2 | sel_md3 | sel_md4;

    // Read mux; unmapped addresses answer zero with an error
    wire [15:0] read_word =
        ({16{sel_div}} & clock_divisor_register_q) |
        ({16{sel_aux}} & pwm_aux_control_q) |
        ({16{sel_md1}} & module_disable_timers_serial_q) |
        ({16{sel_md2}} & module_disable_capture_compare_q) |
        ({16{sel_md3}} & module_disable_comparator_encoder_q) |
        ({16{sel_md4}} & module_disable_refclk_q);

    wire [15:0] wdata = apb_req.pwdata[15:0];

    // Bus answer flops: one access cycle, so pready is high in every access
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_phase;
            pslverr_q <= setup_phase & ~sel_any;
            prdata_q <= setup_phase ? {16'h0000, read_word} : 32'h0000_0000;
        end
    end

    assign apb_rsp.pready = pready_q;
    assign apb_rsp.pslverr = pslverr_q;
    assign apb_rsp.prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Clock divisor register

    wire roi_q = clock_divisor_register_q[`BIT_RETURN_ON_INTERRUPT];
    wire slowdown_q = clock_divisor_register_q[`BIT_CPU_SLOWDOWN_ENABLE];
    wire [2:0] doze_ratio_q =
        clock_divisor_register_q[`MSB_DOZE_RATIO:`LSB_DOZE_RATIO];

    // interrupt wake-up
    // An interrupt beats a same-cycle write so the wake-up is never lost
    wire interrupt_wake = irq_event & roi_q;

    wire [15:0] div_written = write_done & sel_div ?
        (wdata & `MASK_CLOCK_DIVISOR) : clock_divisor_register_q;
    wire [15:0] clock_divisor_register_d = interrupt_wake ?
        (div_written & ~(16'h0001 << `BIT_CPU_SLOWDOWN_ENABLE)) :
        div_written;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clock_divisor_register_q <= `RST_CLOCK_DIVISOR;
        end else begin
            clock_divisor_register_q <= clock_divisor_register_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // PWM fine-resolution control and module disable registers

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_aux_control_q <= `RST_PWM_AUX;
            module_disable_timers_serial_q <= `RST_MODULE_DISABLE;
            module_disable_capture_compare_q <= `RST_MODULE_DISABLE;
            module_disable_comparator_encoder_q <= `RST_MODULE_DISABLE;
            module_disable_refclk_q <= `RST_MODULE_DISABLE;
        end else begin
            if (write_done & sel_aux) begin
                pwm_aux_control_q <= wdata & `MASK_PWM_AUX;
            end
            if (write_done & sel_md1) begin
                module_disable_timers_serial_q <=
                    wdata & `MASK_MD_TIMERS_SERIAL;
            end
            if (write_done & sel_md2) begin
                module_disable_capture_compare_q <=
                    wdata & `MASK_MD_CAPTURE_COMPARE;
            end
            if (write_done & sel_md3) begin
                module_disable_comparator_encoder_q <=
                    wdata & `MASK_MD_COMPARATOR_ENCODER;
            end
            if (write_done & sel_md4) begin
                module_disable_refclk_q <= wdata & `MASK_MD_REFCLK;
            end
        end
    end

    assign fine_duty_disable_q = pwm_aux_control_q[7:0];
    assign fine_period_disable_q = pwm_aux_control_q[15:8];

    // timers, encoder 1, PWM, serial, CAN, ADC
    // reference clock generator
    // Vector order, msb first: refclk, comparator, encoder2, i2c_two,
    // capture4..1, compare4..1, timer5..1, encoder1, pwm_unit,
    // i2c_one, uart_two, uart_one, spi_two, spi_one, can_one, adc
    wire [`MODULE_COUNT-1:0] module_off = {
        module_disable_refclk_q[3],
        module_disable_comparator_encoder_q[10],
        module_disable_comparator_encoder_q[5],
        module_disable_comparator_encoder_q[1],
        module_disable_capture_compare_q[11:8],
        module_disable_capture_compare_q[3:0],
        module_disable_timers_serial_q[15:9],
        module_disable_timers_serial_q[7:3],
        module_disable_timers_serial_q[1:0]
    };

    ////////////////////////////////////////////////////////////////////////
    // Doze divider

    // mask of 2^n - 1 selects division by 2^n
    wire [`DOZE_COUNT_WIDTH-1:0] ratio_mask =
        7'h7f >> (3'd7 - doze_ratio_q);
    wire cpu_tick_d = ~slowdown_q | ((doze_count_q & ratio_mask) == ratio_mask);

    // enables come straight from flops
    // Counter restarts on leaving doze so re-entry begins a full period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            doze_count_q <= 7'h00;
            cpu_clk_en_q <= 1'b1;
            cpu_mode_q <= MODE_FULL;
        end else begin
            doze_count_q <= slowdown_q ? doze_count_q + 7'h01 : 7'h00;
            cpu_clk_en_q <= cpu_tick_d;
            cpu_mode_q <= slowdown_q ? MODE_DOZE : MODE_FULL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Module enables and peripheral access gating

    // enabled only if present and not disabled
    wire [`MODULE_COUNT-1:0] module_enable_d = ~module_off & PRESENT_MASK;

    // change lands on the next instruction cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            module_enable_q <= {`MODULE_COUNT{1'b1}};
        end else if (cpu_clk_en_q) begin
            module_enable_q <= module_enable_d;
        end
    end

    // peripheral clocks never divided by doze
    assign periph_clk_en_q = module_enable_q & PRESENT_MASK;

    wire access_hit = |(periph_sel & module_enable_q & PRESENT_MASK);

    // access strobes aligned with the CPU tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            periph_wr_en_q <= 1'b0;
            periph_rd_valid_q <= 1'b0;
        end else begin
            periph_wr_en_q <= periph_wr & access_hit & cpu_tick_d;
            periph_rd_valid_q <= periph_rd & access_hit & cpu_tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_full_speed_tick: assert property (
        !slowdown_q |=> cpu_clk_en_q)
        else $error("CPU enable low while not in doze");

    // A ratio change keeps the counter running but can shift the tick phase, so that cycle is left out
    chk_ratio_two_gap: assert property (
        slowdown_q && doze_ratio_q == 3'd1 && $stable(slowdown_q)
            && $stable(doze_ratio_q)
            && cpu_clk_en_q && $past(slowdown_q)
        |=> !cpu_clk_en_q)
        else $error("Ratio 1:2 gave two ticks in a row");

    chk_ratio_four_tick: assert property (
        slowdown_q && doze_ratio_q == 3'd2 && cpu_tick_d
            && $past(slowdown_q, 4) && $stable(clock_divisor_register_q)
            && $past(doze_ratio_q, 4) == 3'd2
        |-> $past(cpu_tick_d, 4) && !$past(cpu_tick_d, 1))
        else $error("Ratio 1:4 tick spacing wrong");

    chk_interrupt_wake: assert property (
        irq_event && roi_q |=> !slowdown_q ##1 cpu_clk_en_q)
        else $error("Interrupt did not restore full speed");

    chk_interrupt_ignored: assert property (
        irq_event && !roi_q && slowdown_q && !(write_done && sel_div)
        |=> slowdown_q)
        else $error("Interrupt left doze without return flag");

    chk_periph_clock_on: assert property (
        slowdown_q && module_enable_q == module_enable_d
        |=> $stable(periph_clk_en_q))
        else $error("Peripheral clock gated by doze");

    chk_disable_delay: assert property (
        $changed(module_enable_q) |-> $past(cpu_clk_en_q))
        else $error("Module enable moved off the CPU tick");

    chk_disabled_clock: assert property (
        module_off[3] && cpu_clk_en_q |=> !periph_clk_en_q[3])
        else $error("Disabled module still clocked");

    chk_blocked_write: assert property (
        periph_wr && ((periph_sel & module_enable_q) == '0)
        |=> !periph_wr_en_q)
        else $error("Write passed to a disabled module");

    chk_reserved_zero: assert property (
        (module_disable_refclk_q & ~`MASK_MD_REFCLK) == 16'h0000
        && (module_disable_comparator_encoder_q
            & ~`MASK_MD_COMPARATOR_ENCODER) == 16'h0000)
        else $error("Unimplemented disable bit set");

    chk_access_on_tick: assert property (
        periph_wr_en_q || periph_rd_valid_q |-> cpu_clk_en_q)
        else $error("Peripheral access off the CPU tick");

    chk_blocked_read: assert property (
        periph_rd && ((periph_sel & module_enable_q) == '0)
        |=> !periph_rd_valid_q)
        else $error("Read passed to a disabled module");

    // Catches an enable register that skips or repeats an update
    chk_enable_follow: assert property (
        cpu_clk_en_q |=> module_enable_q == $past(module_enable_d))
        else $error("Module enable missed its tick");

    chk_doze_flag: assert property (
        slowdown_q |=> cpu_mode_q == MODE_DOZE)
        else $error("Doze state flag not raised");

    chk_write_passes: assert property (
        periph_wr && access_hit && cpu_tick_d |=> periph_wr_en_q)
        else $error("Write to an enabled module dropped");

    chk_divisor_mask: assert property (
        (clock_divisor_register_q & ~`MASK_CLOCK_DIVISOR) == 16'h0000)
        else $error("Unimplemented divisor bit set");

    cov_doze_max: cover property (
        slowdown_q && doze_ratio_q == 3'd7 && cpu_clk_en_q);
    cov_wake: cover property (irq_event && roi_q && slowdown_q);
    cov_disable_enable: cover property (
        !module_enable_q[1] ##[1:40] module_enable_q[1]);
    cov_blocked_write: cover property (periph_wr && !access_hit);
    cov_ratio_two: cover property (
        slowdown_q && doze_ratio_q == 3'd1 && cpu_clk_en_q);

endmodule : power_saving_clock_gating

/* sim/tb.sv */
// Self-checking bench for the power-saving clock control block.
// Assumes the package and constants header are on the include path.
`timescale 1ns/1ps

module tb;
    import clock_gating_pkg::*;

    // Refclk generator left out of this variant to show absent modules
    localparam logic [25:0] PMASK = 26'h1ffffff;

    typedef struct {
        logic [11:0] a;
        logic [15:0] w;
        logic [15:0] r;
        logic [25:0] e;
    } row_type;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    apb_req_type req = '0;
    apb_rsp_type rsp;
    logic irq_event = 1'b0;
    logic [25:0] periph_sel = '0;
    logic periph_wr = 1'b0;
    logic periph_rd = 1'b0;
    logic cpu_en, wr_en, rd_val, mode;
    logic [25:0] en;
    logic [7:0] duty, period;
    logic [31:0] rd;
    logic err;
    logic [15:0] aux_e;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int cnt, bad;

    // Address, write data, expected read-back, expected clock enables
    row_type rows [6] = '{
        '{12'h000, 16'hf7ff, 16'hf000, PMASK},
        '{12'h004, 16'ha55a, 16'ha55a, PMASK},
        '{12'h008, 16'hffff, 16'hfefb, PMASK & ~26'h0003fff},
        '{12'h00c, 16'hffff, 16'h0f0f, PMASK & ~26'h03fc000},
        '{12'h010, 16'hffff, 16'h0422, PMASK & ~26'h1c00000},
        '{12'h014, 16'hffff, 16'h0008, PMASK & ~26'h2000000}};

    power_saving_clock_gating #(.PRESENT_MASK(PMASK)) u_dut (
        .clk(clk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
        .irq_event(irq_event), .periph_sel(periph_sel),
        .periph_wr(periph_wr), .periph_rd(periph_rd),
        .cpu_clk_en_q(cpu_en), .periph_clk_en_q(en),
        .periph_wr_en_q(wr_en), .periph_rd_valid_q(rd_val),
        .fine_duty_disable_q(duty), .fine_period_disable_q(period),
        .cpu_mode_q(mode));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the ceiling is well above the planned run
    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            err_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One APB transfer; returns right at the edge where pready is taken
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [15:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: {16'h0000, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : xfer

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset_enables", PMASK, en);
        chk("reset_cpu_en", 1, cpu_en);
        $display("test reset done");
        // Register table: reset value, masks, bit map, enable timing
        foreach (rows[i]) begin
            xfer(1'b0, rows[i].a, 16'h0000);
            chk("reset_value", 0, rd);
            xfer(1'b1, rows[i].a, rows[i].w);
            #1 chk("enables_hold", PMASK, en);
            @(posedge clk);
            #1 chk("enables_after", rows[i].e, en);
            aux_e = (i == 1) ? 16'ha55a : 16'h0000;
            chk("pwm_aux", aux_e, {period, duty});
            xfer(1'b0, rows[i].a, 16'h0000);
            chk("readback", rows[i].r, rd);
            xfer(1'b1, rows[i].a, 16'h0000);
        end
        xfer(1'b0, 12'h018, 16'h0000);
        chk("unmapped_err", 1, err);
        chk("unmapped_data", 0, rd);
        // Aux was written back to zero in the table above, so software reloads aux
        xfer(1'b1, 12'h004, 16'h00ff);
        xfer(1'b0, 12'h004, 16'h0000);
        chk("pwm_reload", 16'h00ff, rd);
        chk("fine_duty", 8'hff, duty);
        chk("fine_period", 8'h00, period);
        $display("test registers done");
        // Every ratio, with interrupts present but return flag clear
        for (int n = 0; n < 8; n++) begin
            xfer(1'b1, 12'h000, {1'b0, n[2:0], 12'h800});
            irq_event <= 1'b1;
            repeat (140) @(posedge clk);
            cnt = 0;
            bad = 0;
            repeat (256) begin
                @(posedge clk);
                cnt += (cpu_en === 1'b1);
                bad += (en !== PMASK);
            end
            chk("doze_ticks", 256 >> n, cnt);
            chk("periph_full", 0, bad);
            chk("doze_mode", 1, mode);
            irq_event <= 1'b0;
        end
        $display("test doze done");
        // Return flag set: one interrupt restores full speed
        xfer(1'b1, 12'h000, 16'hb800);
        repeat (20) @(posedge clk);
        irq_event <= 1'b1;
        @(posedge clk);
        irq_event <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("irq_full_speed", 1, cpu_en);
        @(posedge clk);
        #1 chk("irq_still_full", 1, cpu_en);
        xfer(1'b0, 12'h000, 16'h0000);
        chk("irq_clears_bit", 16'hb000, rd);
        xfer(1'b1, 12'h000, 16'h0000);
        $display("test interrupt return done");
        // Peripheral access passes while enabled, refused while disabled
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            periph_sel <= 26'h0000001;
            periph_wr <= 1'b1;
            periph_rd <= 1'b1;
            @(posedge clk);
            periph_wr <= 1'b0;
            periph_rd <= 1'b0;
            #1 chk("periph_access", {2{k == 0}}, {wr_en, rd_val});
            xfer(1'b1, 12'h008, 16'h0001);
            repeat (2) @(posedge clk);
        end
        xfer(1'b1, 12'h008, 16'h0000);
        $display("test peripheral access done");
        // Reset in mid-run with doze and a disable bit both set
        xfer(1'b1, 12'h000, 16'h0800);
        xfer(1'b1, 12'h008, 16'h0001);
        repeat (3) @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1 chk("rerst_enables", PMASK, en);
        chk("rerst_cpu_en", 1, cpu_en);
        chk("rerst_mode", 0, mode);
        xfer(1'b0, 12'h000, 16'h0000);
        chk("rerst_divisor", 0, rd);
        xfer(1'b0, 12'h008, 16'h0000);
        chk("rerst_disable", 0, rd);
        $display("test mid-run reset done");
        end_sim();
    end

endmodule : tb
